// File: inc/scr_pkg.sv
// Overview of operation
// - Watchdog scale zero disables; n gives timeout 2.5 s times 2^(n-1).
// - Lock bit set blocks host writes to 0x81..0x120, except 0x100.
// - Clock-calendar enable bit turns real-time clock and alarm on or off.
// - Shutdown core-off bit plus reset mode switches off everything incl. core.
// - Low_power_state core-off bit plus low-power state switches off everything.
// - Wake command bit leaves low-power state and clears itself.
// - Reset-mode command bit powers down to reset mode, self-clearing.
// - Host kicks watchdog before timeout; device restarts timer, clears bit.
// - Control-output disable drops system, power, power1 enables in low power.
// - Low power: bits 6,5,4 stop slow clock, charger, calendar updates.
// - Low power: bit 2 stops host interface, bit 0 suppresses input events.
// - Cleared wake-disable lets passive-to-active input wake; set blocks wake.
// - Polarity bit sets active level: one high, zero low.
// - Pin 0 function: trigger input, input, open-drain, push-pull.
// - Pins 1,3 function: reserved, input, open-drain, push-pull.
// - Pin 2 function: power enable input, input, open-drain, fault output.
// - Pin 4 function: system enable input, input, open-drain, push-pull.
// - Wake-sense bit per pin: zero edge, one level detection.
// - Mode bit: static output value, output polarity, or input debounce.
// - Shared 3-bit debounce select: 000 none, up to 1024 ms.
// - Output-static bit set drives static level from the mode bit.
`default_nettype none
package scr_pkg;
  localparam int          NREG    = 9;
  localparam logic [8:0]  REG_ADR [NREG] = '{9'h011, 9'h012, 9'h013,
    9'h014, 9'h015, 9'h016, 9'h017, 9'h01C, 9'h01D};
  localparam int          IX_WDG  = 0;
  localparam int          IX_LCK  = 1;
  localparam int          IX_CMD  = 2;
  localparam int          IX_LPD  = 3;
  localparam int          IX_P01  = 4;
  localparam int          IX_P23  = 5;
  localparam int          IX_P4   = 6;
  localparam int          IX_WKS  = 7;
  localparam int          IX_MOD  = 8;
  localparam logic [7:0]  REG_RST = 8'h00;
  localparam logic [8:0]  LOCK_LO = 9'h081;
  localparam logic [8:0]  LOCK_HI = 9'h120;
  localparam logic [8:0]  LOCK_EX = 9'h100;
  localparam int          B_LOCK  = 7;
  localparam int          B_RTC   = 2;
  localparam int          B_SD    = 1;
  localparam int          B_PD    = 0;
  localparam int          B_WAKE  = 2;
  localparam int          B_SHUT  = 1;
  localparam int          B_KICK  = 0;
  localparam int          B_CODIS = 7;
  localparam int          B_CLK   = 6;
  localparam int          B_CHG   = 5;
  localparam int          B_CAL   = 4;
  localparam int          B_HIF   = 2;
  localparam int          B_GPI   = 0;
  localparam logic [1:0]  F_ALT   = 2'h0;
  localparam logic [1:0]  F_IN    = 2'h1;
  localparam logic [1:0]  F_OD    = 2'h2;
  localparam logic [1:0]  F_PP    = 2'h3;
  localparam int unsigned CLK_HZ  = 10_000_000;
  localparam int unsigned WDG_MS  = 2500;
  localparam int unsigned WDG_CYC = WDG_MS * (CLK_HZ / 1000);
  localparam int unsigned DB_US [8] = '{0, 100, 1000, 10240, 51200,
    256000, 512000, 1024000};
  localparam int unsigned DB_CYC [8] = '{1, DB_US[1] * (CLK_HZ / 1000000),
    DB_US[2] * (CLK_HZ / 1000000), DB_US[3] * (CLK_HZ / 1000000),
    DB_US[4] * (CLK_HZ / 1000000), DB_US[5] * (CLK_HZ / 1000000),
    DB_US[6] * (CLK_HZ / 1000000), DB_US[7] * (CLK_HZ / 1000000)};
  typedef struct packed {
    logic       wake_disable;
    logic       input_polarity;
    logic [1:0] pin_function;
  } scr_pin_t;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_DEV  = 5'h02,
    S_ADR  = 5'h04,
    S_WR   = 5'h08,
    S_RD   = 5'h10
  } scr_st_t;
endpackage : scr_pkg
`default_nettype wire

// File: rtl/scr_regs.sv
`default_nettype none
module scr_regs
  import scr_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR = 7'h58,
  parameter int unsigned WDG_BASE = WDG_CYC,
  parameter int unsigned DB_TGT [8] = DB_CYC
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  input  wire logic [4:0] gpio_i,
  output logic      [4:0] gpio_o,
  output logic      [4:0] gpio_oe_n,
  input  wire logic       in_low_power,
  input  wire logic       in_reset_mode,
  input  wire logic [2:0] debounce_sel,
  input  wire logic [4:0] out_static,
  input  wire logic [4:0] out_src,
  input  wire logic       supply_fault,
  input  wire logic       power1_req,
  output logic            wake_req,
  output logic            shutdown_req,
  output logic            wdg_timeout,
  output logic            core_off,
  output logic            rtc_enable,
  output logic            system_domain_enable_in_o,
  output logic            power_domain_enable_in_o,
  output logic            power1_domain_enable_in_o,
  output logic            slow_clock_run,
  output logic            charger_run,
  output logic            calendar_run,
  output logic      [4:0] input_event
);

  // ==========================================================
  // two-wire pin synchronisers
  logic    [2:0] scl_s;
  logic    [2:0] sda_s;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_c;
  logic          stop_c;
  logic          hif_off;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
    end
  end

  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign start_c  = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop_c   = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

  // ==========================================================
  // register file
  logic    [7:0] reg_q [NREG];
  logic    [8:0] adr_q;
  logic    [7:0] sr_q;
  logic    [7:0] rdata;
  logic    [3:0] ridx;
  logic    [3:0] widx;
  logic          wr_pulse;
  logic          wr_ok;
  logic          lp;

  function automatic logic [3:0] scr_idx(input logic [8:0] a);
    scr_idx = 4'hF;
    for (int i = 0; i < NREG; i++) begin
      if (a == REG_ADR[i]) begin
        scr_idx = 4'(i);
      end
    end
  endfunction : scr_idx

  assign lp    = in_low_power;
  assign ridx  = scr_idx(adr_q);
  assign widx  = ridx;
  assign rdata = (ridx == 4'hF) ? 8'h00 : reg_q[ridx];
  assign wr_ok = !(reg_q[IX_LCK][B_LOCK] && adr_q >= LOCK_LO &&
                   adr_q <= LOCK_HI && adr_q != LOCK_EX);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NREG; i++) begin
        reg_q[i] <= REG_RST;
      end
    end else begin
      reg_q[IX_CMD][2:0] <= 3'h0;
      if (wr_pulse && wr_ok && widx != 4'hF) begin
        reg_q[widx] <= sr_q;
      end
    end
  end

  // ==========================================================
  // two-wire slave
  scr_st_t       st_q;
  logic    [3:0] cnt_q;
  logic    [7:0] tx_q;
  logic          sdo_q;
  logic          page_q;
  logic          rd_q;

  assign hif_off  = lp & reg_q[IX_LPD][B_HIF];
  assign wr_pulse = scl_fall && cnt_q == 4'h7 && st_q == S_WR &&
                    !hif_off && !stop_c && !start_c;
  assign sda_o    = 1'b0;
  assign sda_oe_n = sdo_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q   <= S_IDLE;
      cnt_q  <= 4'h0;
      sr_q   <= 8'h00;
      tx_q   <= 8'h00;
      sdo_q  <= 1'b1;
      adr_q  <= 9'h000;
      page_q <= 1'b0;
      rd_q   <= 1'b0;
    end else if (hif_off || stop_c) begin
      st_q  <= S_IDLE;
      sdo_q <= 1'b1;
    end else if (start_c) begin
      st_q  <= S_DEV;
      cnt_q <= 4'hF;
      sdo_q <= 1'b1;
    end else if (scl_rise && st_q != S_IDLE) begin
      if (cnt_q < 4'h8) begin
        sr_q <= {sr_q[6:0], sda_s[1]};
      end else if (st_q == S_RD && sda_s[1]) begin
        st_q <= S_IDLE;
      end
    end else if (scl_fall && st_q != S_IDLE) begin
      if (cnt_q == 4'h7) begin
        cnt_q <= 4'h8;
        case (st_q)
          S_DEV: begin
            if (sr_q[7:2] == DEV_ADDR[6:1]) begin
              sdo_q  <= 1'b0;
              page_q <= sr_q[1];
              rd_q   <= sr_q[0];
            end else begin
              st_q <= S_IDLE;
            end
          end
          S_ADR: begin
            sdo_q <= 1'b0;
            adr_q <= {page_q, sr_q};
          end
          S_WR:    sdo_q <= 1'b0;
          S_RD: begin
            sdo_q <= 1'b1;
            adr_q <= adr_q + 9'h001;
          end
          default: st_q <= S_IDLE;
        endcase
      end else if (cnt_q == 4'h8) begin
        cnt_q <= 4'h0;
        sdo_q <= 1'b1;
        case (st_q)
          S_DEV: begin
            st_q <= rd_q ? S_RD : S_ADR;
            if (rd_q) begin
              tx_q  <= rdata;
              sdo_q <= rdata[7];
            end
          end
          S_ADR:   st_q <= S_WR;
          S_WR:    adr_q <= adr_q + 9'h001;
          S_RD: begin
            tx_q  <= rdata;
            sdo_q <= rdata[7];
          end
          default: st_q <= S_IDLE;
        endcase
      end else begin
        cnt_q <= cnt_q + 4'h1;
        if (st_q == S_RD) begin
          sdo_q <= tx_q[6];
          tx_q  <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  // ==========================================================
  // general-purpose pins
  logic     [4:0] gp_s1;
  logic     [4:0] gp_s2;
  logic     [4:0] act_db;
  logic     [4:0] act_prev;
  logic     [4:0] pin_in;
  logic     [4:0] pin_wake;
  logic     [4:0] mode;
  scr_pin_t       pcfg [5];

  assign pcfg[0] = reg_q[IX_P01][3:0];
  assign pcfg[1] = reg_q[IX_P01][7:4];
  assign pcfg[2] = reg_q[IX_P23][3:0];
  assign pcfg[3] = reg_q[IX_P23][7:4];
  assign pcfg[4] = reg_q[IX_P4][3:0];
  assign mode    = reg_q[IX_MOD][4:0];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gp_s1    <= 5'h00;
      gp_s2    <= 5'h00;
      act_prev <= 5'h00;
    end else begin
      gp_s1    <= gpio_i;
      gp_s2    <= gp_s1;
      act_prev <= act_db;
    end
  end

  for (genvar p = 0; p < 5; p++) begin : g_pin
    logic [23:0] db_cnt;
    logic        act;
    logic        db_en;
    logic        rise;
    logic        src;
    logic        val;

    assign act   = pcfg[p].input_polarity ? gp_s2[p] : ~gp_s2[p];
    assign pin_in[p] = (pcfg[p].pin_function == F_IN) ||
                       (pcfg[p].pin_function == F_ALT && p != 1 &&
                        p != 3);
    assign db_en = pin_in[p] && mode[p] && debounce_sel != 3'h0;
    assign rise  = act_db[p] & ~act_prev[p];
    assign pin_wake[p] = pin_in[p] && !pcfg[p].wake_disable &&
                         (reg_q[IX_WKS][p] ? act_db[p] : rise);
    assign src   = (p == 2 && pcfg[p].pin_function == F_PP) ?
                   supply_fault : out_src[p];
    assign val   = out_static[p] ? mode[p] :
                   (mode[p] ? src : ~src);

    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        db_cnt    <= 24'h000000;
        act_db[p] <= 1'b0;
      end else if (!db_en) begin
        db_cnt    <= 24'h000000;
        act_db[p] <= act;
      end else if (act == act_db[p]) begin
        db_cnt    <= 24'h000000;
      end else if (db_cnt >= 24'(DB_TGT[debounce_sel] - 1)) begin
        db_cnt    <= 24'h000000;
        act_db[p] <= act;
      end else begin
        db_cnt    <= db_cnt + 24'h000001;
      end
    end

    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        gpio_o[p]      <= 1'b0;
        gpio_oe_n[p]   <= 1'b1;
        input_event[p] <= 1'b0;
      end else begin
        input_event[p] <= pin_in[p] && rise &&
                          !(lp && reg_q[IX_LPD][B_GPI]);
        case (pcfg[p].pin_function)
          F_OD: begin
            gpio_o[p]    <= 1'b0;
            gpio_oe_n[p] <= val;
          end
          F_PP: begin
            gpio_o[p]    <= val;
            gpio_oe_n[p] <= 1'b0;
          end
          default: begin
            gpio_o[p]    <= 1'b0;
            gpio_oe_n[p] <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // watchdog
  logic    [31:0] wdg_cnt;
  logic    [31:0] wdg_lim;
  logic     [2:0] scale;
  logic           kick;

  assign scale   = reg_q[IX_WDG][2:0];
  assign wdg_lim = WDG_BASE << (scale - 3'h1);
  assign kick    = reg_q[IX_CMD][B_KICK] ||
                   (pcfg[0].pin_function == F_ALT && g_pin[0].rise);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wdg_cnt     <= 32'h00000000;
      wdg_timeout <= 1'b0;
    end else if (scale == 3'h0 || kick) begin
      wdg_cnt     <= 32'h00000000;
      wdg_timeout <= 1'b0;
    end else if (wdg_cnt >= wdg_lim - 32'h1) begin
      wdg_cnt     <= 32'h00000000;
      wdg_timeout <= 1'b1;
    end else begin
      wdg_cnt     <= wdg_cnt + 32'h1;
      wdg_timeout <= 1'b0;
    end
  end

  // ==========================================================
  // power control outputs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wake_req       <= 1'b0;
      shutdown_req   <= 1'b0;
      core_off       <= 1'b0;
      rtc_enable     <= 1'b0;
      system_domain_enable_in_o       <= 1'b0;
      power_domain_enable_in_o       <= 1'b0;
      power1_domain_enable_in_o      <= 1'b0;
      slow_clock_run <= 1'b0;
      charger_run    <= 1'b0;
      calendar_run   <= 1'b0;
    end else begin
      wake_req       <= reg_q[IX_CMD][B_WAKE] ||
                        (lp && |pin_wake);
      shutdown_req   <= reg_q[IX_CMD][B_SHUT];
      core_off       <= (in_reset_mode && reg_q[IX_LCK][B_SD]) ||
                        (lp && reg_q[IX_LCK][B_PD]);
      rtc_enable     <= reg_q[IX_LCK][B_RTC];
      system_domain_enable_in_o       <= pcfg[4].pin_function == F_ALT && act_db[4] &&
                        !(lp && reg_q[IX_LPD][B_CODIS]);
      power_domain_enable_in_o       <= pcfg[2].pin_function == F_ALT && act_db[2] &&
                        !(lp && reg_q[IX_LPD][B_CODIS]);
      power1_domain_enable_in_o      <= power1_req &&
                        !(lp && reg_q[IX_LPD][B_CODIS]);
      slow_clock_run <= !(lp && reg_q[IX_LPD][B_CLK]);
      charger_run    <= !(lp && reg_q[IX_LPD][B_CHG]);
      calendar_run   <= !(lp && reg_q[IX_LPD][B_CAL]);
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  property p_lock_block;
    wr_pulse && reg_q[IX_LCK][B_LOCK] && adr_q == LOCK_HI |-> !wr_ok;
  endproperty
  a_lock_block: assert property (p_lock_block)
    else $error("locked write accepted");

  property p_wake_clear;
    reg_q[IX_CMD][B_WAKE] ##1 !wr_pulse |-> !reg_q[IX_CMD][B_WAKE];
  endproperty
  a_wake_clear: assert property (p_wake_clear)
    else $error("wake command not cleared");

  property p_shut_pulse;
    reg_q[IX_CMD][B_SHUT] |=> shutdown_req;
  endproperty
  a_shut_pulse: assert property (p_shut_pulse)
    else $error("shutdown request missing");

  property p_wdg_off;
    scale == 3'h0 |=> wdg_cnt == 32'h0 && !wdg_timeout;
  endproperty
  a_wdg_off: assert property (p_wdg_off)
    else $error("watchdog runs while disabled");

  property p_kick;
    reg_q[IX_CMD][B_KICK] |=> wdg_cnt == 32'h0;
  endproperty
  a_kick: assert property (p_kick)
    else $error("kick did not restart watchdog");

  property p_core_off;
    lp && reg_q[IX_LCK][B_PD] |=> core_off;
  endproperty
  a_core_off: assert property (p_core_off)
    else $error("core not off in low power");

  property p_codis;
    lp && reg_q[IX_LPD][B_CODIS] |=> !system_domain_enable_in_o && !power_domain_enable_in_o;
  endproperty
  a_codis: assert property (p_codis)
    else $error("domain enable active in low power");

  property p_clk_pause;
    lp && reg_q[IX_LPD][B_CLK] |=> !slow_clock_run;
  endproperty
  a_clk_pause: assert property (p_clk_pause)
    else $error("slow clock not paused");

  property p_evt_dis;
    lp && reg_q[IX_LPD][B_GPI] |=> input_event == 5'h00;
  endproperty
  a_evt_dis: assert property (p_evt_dis)
    else $error("input event in low power");

  property p_pin0_in;
    pcfg[0].pin_function == F_ALT |=> gpio_oe_n[0];
  endproperty
  a_pin0_in: assert property (p_pin0_in)
    else $error("trigger pin driven");

  c_write: cover property (wr_pulse && wr_ok);
  c_read: cover property (st_q == S_RD && scl_fall);
  c_tmo: cover property (wdg_timeout);
  c_wake: cover property (lp && |pin_wake);

endmodule : scr_regs
`default_nettype wire

// File: sim/scr_host.sv
`default_nettype none
module scr_host
  import scr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h58
) (
  input  wire logic mclk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // bus phases, sda moves while scl low except in start and stop
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic half;
    repeat (5) @(posedge mclk);
    #10;
  endtask : half
  task automatic step(input logic d, input logic c);
    @(posedge mclk);
    #10;
    sda_drv = d;
    half;
    scl = c;
  endtask : step
  task automatic start;
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
  endtask : start
  task automatic bit_io(input logic b, output logic r);
    step(b, 1'b1);
    half;
    r = sda_in;
    scl = 1'b0;
  endtask : bit_io
  task automatic xfer(input logic [7:0] tx, input logic nak,
                      output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(nak, r);
    ack = ~r;
  endtask : xfer
  // ==========================================
  // register transfers
  task automatic wr(input logic [8:0] a, input logic [7:0] d,
                    output logic ok);
    logic [7:0] x;
    logic [2:0] k;
    start;
    xfer({DEV_ADDR[6:1], a[8], 1'b0}, 1'b1, x, k[2]);
    xfer(a[7:0], 1'b1, x, k[1]);
    xfer(d, 1'b1, x, k[0]);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    ok = &k;
  endtask : wr
  task automatic rd(input logic [8:0] a, output logic [7:0] d,
                    output logic ok);
    logic [7:0] x;
    logic [2:0] k;
    logic       n;
    start;
    xfer({DEV_ADDR[6:1], a[8], 1'b0}, 1'b1, x, k[2]);
    xfer(a[7:0], 1'b1, x, k[1]);
    start;
    xfer({DEV_ADDR[6:1], a[8], 1'b1}, 1'b1, x, k[0]);
    xfer(8'hFF, 1'b1, d, n);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    ok = &k;
  endtask : rd
endmodule : scr_host
`default_nettype wire

// File: sim/tb_system_and_gpio_control_regs.sv
`default_nettype none
module tb_system_and_gpio_control_regs
  import scr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned DB_T [8] = '{1, 4, 8, 12, 16, 20, 24, 28};
  localparam int          WB       = 20;
  logic       mclk, nrst, scl, sda_drv, sda_w, sda_o, sda_oe_n, ok;
  logic       in_low_power, in_reset_mode, supply_fault, power1_req;
  logic       wake_req, shutdown_req, wdg_timeout, core_off, rtc_enable;
  logic       system_domain_enable_in_o, power_domain_enable_in_o, power1_domain_enable_in_o, slow_clock_run, charger_run;
  logic       calendar_run;
  logic [2:0] debounce_sel;
  logic [4:0] out_static, out_src, pin_drv, gpio_i, gpio_o, gpio_oe_n;
  logic [4:0] input_event, lp_vec;
  int         error_cnt, total_checks, wk_n, sd_n, wd_n, cyc, wd_a, wd_b;
  int         ev_n [5];
  assign sda_w  = sda_drv & (sda_oe_n | sda_o);
  assign gpio_i = (gpio_oe_n & pin_drv) | (~gpio_oe_n & gpio_o);
  assign lp_vec = {core_off, power1_domain_enable_in_o, slow_clock_run, charger_run,
                   calendar_run};
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;
  scr_regs #(.WDG_BASE(WB), .DB_TGT(DB_T)) u_scr_regs (
    .mclk(mclk), .nrst(nrst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .gpio_i(gpio_i), .gpio_o(gpio_o),
    .gpio_oe_n(gpio_oe_n), .in_low_power(in_low_power),
    .in_reset_mode(in_reset_mode), .debounce_sel(debounce_sel),
    .out_static(out_static), .out_src(out_src),
    .supply_fault(supply_fault), .power1_req(power1_req),
    .wake_req(wake_req), .shutdown_req(shutdown_req),
    .wdg_timeout(wdg_timeout), .core_off(core_off),
    .rtc_enable(rtc_enable), .system_domain_enable_in_o(system_domain_enable_in_o), .power_domain_enable_in_o(power_domain_enable_in_o),
    .power1_domain_enable_in_o(power1_domain_enable_in_o), .slow_clock_run(slow_clock_run),
    .charger_run(charger_run), .calendar_run(calendar_run),
    .input_event(input_event));
  scr_host u_scr_host (.mclk(mclk), .sda_in(sda_w), .scl(scl),
                       .sda_drv(sda_drv));
  // ==========================================
  // pulse counters
  always @(posedge mclk) begin
    cyc++;
    wk_n += int'(wake_req === 1'b1);
    sd_n += int'(shutdown_req === 1'b1);
    if (wdg_timeout === 1'b1) begin
      wd_n++;
      wd_a = wd_b;
      wd_b = cyc;
    end
    for (int i = 0; i < 5; i++) ev_n[i] += int'(input_event[i] === 1'b1);
  end
  // ==========================================
  // helpers
  task automatic end_of_test;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] g, e, input string s);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask : tick
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    u_scr_host.wr(a, d, ok);
    chk(8'(ok), 8'h01, "ack");
  endtask : wr
  task automatic rd(input logic [8:0] a, input logic [7:0] e,
                    input string s);
    logic [7:0] d;
    u_scr_host.rd(a, d, ok);
    chk(d, e, s);
  endtask : rd
  task automatic pins(input logic [4:0] w, p, input logic [1:0] f);
    wr(REG_ADR[IX_P01], {w[1], p[1], f, w[0], p[0], f});
    wr(REG_ADR[IX_P23], {w[3], p[3], f, w[2], p[2], f});
    wr(REG_ADR[IX_P4], {4'h0, w[4], p[4], f});
  endtask : pins
  function automatic int wdg_exp(input int n);
    return WB << (n - 1);
  endfunction : wdg_exp
  function automatic logic [4:0] pp_exp(input logic [4:0] m, s);
    return ~(m ^ s);
  endfunction : pp_exp
  initial begin
    #8_000_000;
    error_cnt++;
    end_of_test;
  end
  // ==========================================
  // main sequence
  initial begin : main
    logic [7:0] v [NREG];
    logic [4:0] p, w, m;
    logic [2:0] s;
    int         k, j;
    void'($urandom(9));
    {nrst, in_low_power, in_reset_mode, supply_fault, power1_req} = 5'h00;
    {debounce_sel, out_static, out_src, pin_drv} = 18'h0;
    tick(4);
    nrst = 1'b1;
    tick(4);
    for (int i = 0; i < NREG; i++) begin
      rd(REG_ADR[i], REG_RST, "reset");
      v[i] = (i == IX_CMD) ? 8'h00 : 8'($urandom);
      if (i != IX_CMD) wr(REG_ADR[i], v[i]);
    end
    for (int i = 0; i < NREG; i++) rd(REG_ADR[i], v[i], "readback");
    chk(8'(rtc_enable), 8'(v[IX_LCK][B_RTC]), "rtc");
    k = sd_n;
    wr(REG_ADR[IX_CMD], 8'h02);
    chk(8'(sd_n - k), 8'h01, "shutdown");
    k = wk_n;
    wr(REG_ADR[IX_CMD], 8'h04);
    chk(8'(wk_n - k), 8'h01, "wake");
    rd(REG_ADR[IX_CMD], 8'h00, "self clear");
    wr(REG_ADR[IX_WDG], 8'h03);
    tick(400);
    k = wd_b - wd_a - wdg_exp(3);
    chk(8'(k inside {0, 1}), 8'h01, "wdg period");
    wr(REG_ADR[IX_WDG], 8'h07);
    k = wd_n;
    repeat (6) wr(REG_ADR[IX_CMD], 8'h01);
    chk(8'(wd_n - k), 8'h00, "kicked");
    tick(wdg_exp(7) + 120);
    chk(8'(wd_n - k), 8'h01, "expiry");
    wr(REG_ADR[IX_WDG], 8'h00);
    k = wd_n;
    tick(2 * wdg_exp(7));
    chk(8'(wd_n - k), 8'h00, "wdg off");
    power1_req = 1'b1;
    wr(REG_ADR[IX_LCK], 8'h01);
    chk(8'(rtc_enable), 8'h00, "rtc off");
    s = 3'($urandom);
    wr(REG_ADR[IX_LPD], {1'b1, s, 4'h5});
    in_low_power = 1'b1;
    tick(4);
    chk(8'(lp_vec), 8'({2'b10, ~s}), "low power");
    u_scr_host.wr(REG_ADR[IX_LPD], 8'h00, ok);
    chk(8'(ok), 8'h00, "bus off");
    in_low_power = 1'b0;
    in_reset_mode = 1'b1;
    tick(4);
    chk(8'(lp_vec), 8'h0F, "awake");
    wr(REG_ADR[IX_LCK], 8'h02);
    chk(8'(core_off), 8'h01, "reset mode");
    in_reset_mode = 1'b0;
    m = 5'($urandom);
    out_static = 5'h1F;
    wr(REG_ADR[IX_MOD], 8'(m));
    pins(5'h00, 5'h00, F_PP);
    chk(8'(gpio_o & 5'h1B), 8'(m & 5'h1B), "static");
    chk(8'(gpio_oe_n), 8'h00, "push-pull");
    out_src = 5'($urandom);
    out_static = 5'h00;
    tick(4);
    chk(8'(gpio_o & 5'h1B), 8'(pp_exp(m, out_src) & 5'h1B), "pol");
    out_static = 5'h1F;
    pins(5'h00, 5'h00, F_OD);
    chk(8'(gpio_oe_n), 8'(m), "open drain");
    p = 5'($urandom);
    pin_drv = ~p;
    wr(REG_ADR[IX_MOD], 8'h00);
    wr(REG_ADR[IX_WKS], 8'h01);
    pins(5'h00, p, F_IN);
    for (int i = 0; i < 5; i++) begin
      k = ev_n[i];
      pin_drv[i] = p[i];
      tick(8);
      pin_drv[i] = ~p[i];
      tick(8);
      chk(8'(ev_n[i] - k), 8'h01, "event");
    end
    w = 5'($urandom) & 5'h1E;
    wr(REG_ADR[IX_LPD], 8'h01);
    pins(w, p, F_IN);
    in_low_power = 1'b1;
    tick(4);
    for (int i = 4; i >= 0; i--) begin
      k = wk_n;
      j = ev_n[i];
      pin_drv[i] = p[i];
      tick(8);
      if (i > 0) chk(8'(wk_n - k), 8'(!w[i]), "edge wake");
      chk(8'(ev_n[i] - j), 8'h00, "event off");
    end
    tick(20);
    chk(8'(wake_req), 8'h01, "level wake");
    in_low_power = 1'b0;
    pin_drv = ~p;
    s = 3'($urandom_range(7, 1));
    debounce_sel = s;
    wr(REG_ADR[IX_MOD], 8'h02);
    k = ev_n[1];
    pin_drv[1] = p[1];
    tick(DB_T[s] / 2);
    pin_drv[1] = ~p[1];
    tick(DB_T[s] + 10);
    chk(8'(ev_n[1] - k), 8'h00, "glitch");
    pin_drv[1] = p[1];
    tick(DB_T[s] + 10);
    chk(8'(ev_n[1] - k), 8'h01, "debounced");
    wr(REG_ADR[IX_MOD], 8'h00);
    pins(5'h00, p, F_ALT);
    pin_drv = p;
    tick(8);
    chk(8'({system_domain_enable_in_o, power_domain_enable_in_o}), 8'h03, "domain in");
    chk(8'(gpio_oe_n & 5'h0A), 8'h0A, "reserved pin");
    end_of_test;
  end
endmodule : tb_system_and_gpio_control_regs
`default_nettype wire
